// ==== err_irq_pkg.sv ====
package err_irq_pkg;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [3:0] OFS_ERR_EN   = 4'h6;
  localparam logic [3:0] OFS_EVT_EN   = 4'h7;
  localparam logic [3:0] OFS_ERR_FLAG = 4'h8;
  localparam logic [3:0] OFS_CTRL     = 4'hc;
  localparam logic [3:0] OFS_STATUS   = 4'hd;

  localparam int BIT_IA    = 7;
  localparam int BIT_CMD   = 6;
  localparam int BIT_EOL   = 5;
  localparam int BIT_TRIG  = 3;
  localparam int BIT_RSTAR = 2;
  localparam int BIT_ALT_LIST_LOAD_OK  = 1;
  localparam int BIT_ABORT = 7;
  localparam int BIT_OVRN  = 6;
  localparam int BIT_CONV_EN = 0;
  localparam int BIT_SOFT_RST = 1;
  localparam int BIT_RESTART_MODE = 2;

  localparam logic [7:0] ERR_EN_MASK  = 8'hee;
  localparam logic [7:0] EVT_EN_MASK  = 8'hc0;
  localparam logic [7:0] SEVERE_MASK  = 8'he8;
  localparam logic [7:0] MILD_MASK    = 8'h06;
  localparam logic [7:0] RST_ERR_EN   = 8'h00;
  localparam logic [7:0] RST_EVT_EN   = 8'h00;
  localparam logic [7:0] RST_FLAGS    = 8'h00;
  localparam logic [7:0] RST_CTRL     = 8'h00;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic illegal_access;
    logic bad_command;
    logic list_end_missing;
    logic trigger_early;
    logic restart_req_early;
    logic restart_no_load_ok;
  } err_event_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_RUN     = 2'b01,
    ST_HALTED  = 2'b10
  } conv_state_t;

endpackage : err_irq_pkg

// ==== err_flag_bit.sv ====
`timescale 1ns/1ps
`default_nettype none
module err_flag_bit (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic hold_clear,
  input  wire logic soft_clear,
  input  wire logic sw_clear,
  input  wire logic set_evt,
  output var  logic flag_r
);
  // Hardware set wins over software clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_r <= 1'b0;
    end else if (hold_clear || soft_clear) begin
      flag_r <= 1'b0;
    end else if (set_evt) begin
      flag_r <= 1'b1;
    end else if (sw_clear) begin
      flag_r <= 1'b0;
    end
  end
endmodule : err_flag_bit
`default_nettype wire

// ==== reg_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module reg_decode
  import err_irq_pkg::*;
(
  input  wire bus_req_t req,
  output logic          wr_err_en,
  output logic          wr_evt_en,
  output logic          wr_flags,
  output logic          wr_ctrl
);
  assign wr_err_en = req.wr && (req.addr == OFS_ERR_EN);
  assign wr_evt_en = req.wr && (req.addr == OFS_EVT_EN);
  assign wr_flags  = req.wr && (req.addr == OFS_ERR_FLAG);
  assign wr_ctrl   = req.wr && (req.addr == OFS_CTRL);
endmodule : reg_decode
`default_nettype wire

// ==== adc_error_interrupt_logic.sv ====
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module adc_error_interrupt_logic
  import err_irq_pkg::*;
(
  input  wire  logic       clk,
  input  wire  logic       nrst,
  input  wire  logic [3:0] addr,
  input  wire  logic [7:0] wdata,
  input  wire  logic       wr,
  input  wire  logic       rd,
  output logic [7:0]       rdata,
  input  wire  err_event_t err_evt,
  input  wire  logic       abort_done,
  input  wire  logic       conv_overrun,
  output logic             conv_run,
  output logic             err_irq,
  output logic             abort_irq,
  output logic             overrun_irq
);

  // ****************************************
  // Bus decode
  // ****************************************
  bus_req_t   req;
  logic       wr_err_en;
  logic       wr_evt_en;
  logic       wr_flags;
  logic       wr_ctrl;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  reg_decode u_dec (
    .req       (req),
    .wr_err_en (wr_err_en),
    .wr_evt_en (wr_evt_en),
    .wr_flags  (wr_flags),
    .wr_ctrl   (wr_ctrl)
  );

  // ****************************************
  // Control and enable registers
  // ****************************************
  logic [7:0] err_en_r;
  logic [7:0] evt_en_r;
  logic [7:0] ctrl_r;
  logic       soft_rst_r;
  logic       conv_en;
  logic       restart_mode;

  assign conv_en      = ctrl_r[BIT_CONV_EN];
  assign restart_mode = ctrl_r[BIT_RESTART_MODE];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err_en_r   <= RST_ERR_EN;
      evt_en_r   <= RST_EVT_EN;
      ctrl_r     <= RST_CTRL;
      soft_rst_r <= 1'b0;
    end else begin
      if (wr_err_en) err_en_r <= wdata & ERR_EN_MASK;
      if (wr_evt_en) evt_en_r <= wdata & EVT_EN_MASK;
      if (wr_ctrl) ctrl_r <= {5'h00, wdata[BIT_RESTART_MODE], 1'b0,
                              wdata[BIT_CONV_EN]};
      soft_rst_r <= wr_ctrl && wdata[BIT_SOFT_RST];
    end
  end

  // ****************************************
  // Error flags
  // ****************************************
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] flags;
  logic       hold_clear;

  assign hold_clear = !conv_en;
  assign set_vec = {err_evt.illegal_access,
                    err_evt.bad_command,
                    err_evt.list_end_missing,
                    1'b0,
                    err_evt.trigger_early,
                    err_evt.restart_req_early,
                    err_evt.restart_no_load_ok && restart_mode,
                    1'b0};
  // Only write-one on mild bits clears; zero and severe ignored
  assign clr_vec = (wr_flags ? wdata : 8'h00) & MILD_MASK;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      if ((SEVERE_MASK[gi] | MILD_MASK[gi]) == 1'b1) begin : g_impl
        err_flag_bit u_bit (
          .clk        (clk),
          .nrst       (nrst),
          .hold_clear (hold_clear),
          .soft_clear (soft_rst_r),
          .sw_clear   (clr_vec[gi]),
          .set_evt    (set_vec[gi]),
          .flag_r     (flags[gi])
        );
      end else begin : g_rsvd
        assign flags[gi] = 1'b0;
      end
    end
  endgenerate

  // ****************************************
  // Conversion run state
  // ****************************************
  conv_state_t state_r;
  conv_state_t state_nxt;
  logic        severe;

  assign severe = |(flags & SEVERE_MASK);

  always_comb begin
    case (state_r)
      ST_IDLE:   state_nxt = conv_en ? ST_RUN : ST_IDLE;
      ST_RUN:    state_nxt = !conv_en ? ST_IDLE :
                             (severe ? ST_HALTED : ST_RUN);
      ST_HALTED: state_nxt = (!conv_en || soft_rst_r) ?
                             ST_IDLE : ST_HALTED;
      default:   state_nxt = ST_IDLE;
    endcase
  end

  // ****************************************
  // Outputs and read data
  // ****************************************
  logic [7:0] rd_mux;
  logic [7:0] status;

  assign status = {6'h00, state_r};
  assign rd_mux = (addr == OFS_ERR_EN)   ? err_en_r :
                  (addr == OFS_EVT_EN)   ? evt_en_r :
                  (addr == OFS_ERR_FLAG) ? flags :
                  (addr == OFS_CTRL)     ? ctrl_r :
                  (addr == OFS_STATUS)   ? status : 8'h00;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r     <= ST_IDLE;
      rdata       <= 8'h00;
      conv_run    <= 1'b0;
      err_irq     <= 1'b0;
      abort_irq   <= 1'b0;
      overrun_irq <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      rdata       <= rd ? rd_mux : 8'h00;
      conv_run    <= (state_nxt == ST_RUN);
      err_irq     <= |(set_or_flags() & err_en_r);
      abort_irq   <= abort_done && evt_en_r[BIT_ABORT];
      overrun_irq <= conv_overrun && evt_en_r[BIT_OVRN];
    end
  end

  function automatic logic [7:0] set_or_flags();
    set_or_flags = flags;
  endfunction : set_or_flags

  // ****************************************
  // Checks
  // ****************************************
  a_severe_halts: assert property (@(posedge clk) disable iff (!nrst)
    (severe && conv_en && !soft_rst_r) |=> ##1 !conv_run)
    else $error("Severe flag did not stop conversion");
  a_soft_clears: assert property (@(posedge clk) disable iff (!nrst)
    soft_rst_r |=> flags == 8'h00 || $past(|set_vec))
    else $error("Soft-reset left flags set");
  a_mild_runs: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == ST_RUN && conv_en && !severe) |=> state_r == ST_RUN)
    else $error("Mild flag stopped conversion");
  a_severe_no_clear: assert property (@(posedge clk) disable iff (!nrst)
    (|(flags & SEVERE_MASK) && conv_en && !soft_rst_r)
      |=> (flags & SEVERE_MASK) == 8'h00 ? 1'b0 : 1'b1)
    else $error("Severe flag cleared by write");
  a_disabled_clear: assert property (@(posedge clk) disable iff (!nrst)
    !conv_en |=> flags == 8'h00)
    else $error("Flags not held clear while disabled");
  a_write_no_set: assert property (@(posedge clk) disable iff (!nrst)
    (!flags[BIT_ALT_LIST_LOAD_OK] && !set_vec[BIT_ALT_LIST_LOAD_OK]) |=> !flags[BIT_ALT_LIST_LOAD_OK])
    else $error("Load-ok flag set without cause");
  a_alt_list_load_ok_mode: assert property (@(posedge clk) disable iff (!nrst)
    (!restart_mode && !flags[BIT_ALT_LIST_LOAD_OK]) |=> !flags[BIT_ALT_LIST_LOAD_OK])
    else $error("Load-ok flag set outside restart mode");
  a_irq_gate: assert property (@(posedge clk) disable iff (!nrst)
    ##1 err_irq == $past(|(flags & err_en_r)))
    else $error("Error request mismatch");

  // ****************************************
  // Checks on flag setting, soft-reset clearing and reserved bits
  // ****************************************
  logic flag_live;

  assign flag_live = conv_en && !soft_rst_r;

  a_ia_sets: assert property (@(posedge clk) disable iff (!nrst)
    (err_evt.illegal_access && flag_live) |=> flags[BIT_IA])
    else $error("Illegal access flag not set");

  a_cmd_sets: assert property (@(posedge clk) disable iff (!nrst)
    (err_evt.bad_command && flag_live) |=> flags[BIT_CMD])
    else $error("Bad command flag not set");

  a_eol_sets: assert property (@(posedge clk) disable iff (!nrst)
    (err_evt.list_end_missing && flag_live) |=> flags[BIT_EOL])
    else $error("List end flag not set");

  a_trig_sets: assert property (@(posedge clk) disable iff (!nrst)
    (err_evt.trigger_early && flag_live) |=> flags[BIT_TRIG])
    else $error("Trigger flag not set");

  a_rstar_sets: assert property (@(posedge clk) disable iff (!nrst)
    (err_evt.restart_req_early && flag_live)
      |=> flags[BIT_RSTAR])
    else $error("Restart flag not set");

  a_alt_list_load_ok_sets: assert property (@(posedge clk) disable iff (!nrst)
    (err_evt.restart_no_load_ok && restart_mode && flag_live)
      |=> flags[BIT_ALT_LIST_LOAD_OK])
    else $error("Load-ok flag not set");

  a_soft_mild: assert property (@(posedge clk) disable iff (!nrst)
    soft_rst_r |=> !flags[BIT_RSTAR] && !flags[BIT_ALT_LIST_LOAD_OK])
    else $error("Soft-reset left mild flags set");

  a_rsvd_zero: assert property (@(posedge clk) disable iff (!nrst)
    !flags[4] && !flags[0])
    else $error("Reserved flag bit set");

  // ****************************************
  // Checks per flag bit
  // ****************************************
  genvar gc;
  generate
    for (gc = 0; gc < 8; gc++) begin : g_chk
      if (SEVERE_MASK[gc] == 1'b1) begin : g_sev
        a_sev_keep: assert property (@(posedge clk) disable iff (!nrst)
          (flags[gc] && flag_live) |=> flags[gc])
          else $error("Severe flag cleared without soft-reset");
      end

      if (MILD_MASK[gc] == 1'b1) begin : g_mild
        a_mild_clear: assert property (@(posedge clk) disable iff (!nrst)
          (wr_flags && wdata[gc] && !set_vec[gc]) |=> !flags[gc])
          else $error("Mild flag not cleared by write one");

        a_zero_keeps: assert property (@(posedge clk) disable iff (!nrst)
          (wr_flags && !wdata[gc] && flags[gc] && flag_live)
            |=> flags[gc])
          else $error("Mild flag cleared by write zero");
      end

      if (ERR_EN_MASK[gc] == 1'b1) begin : g_gate
        a_gate_on: assert property (@(posedge clk) disable iff (!nrst)
          (flags[gc] && err_en_r[gc]) |=> err_irq)
          else $error("Enabled flag raised no request");
      end
    end
  endgenerate

  // ****************************************
  // Checks on requests
  // ****************************************
  a_irq_quiet: assert property (@(posedge clk) disable iff (!nrst)
    !(|(flags & err_en_r)) |=> !err_irq)
    else $error("Error request without enabled flag");

  a_abort_on: assert property (@(posedge clk) disable iff (!nrst)
    (abort_done && evt_en_r[BIT_ABORT]) |=> abort_irq)
    else $error("Abort request missing");

  a_abort_off: assert property (@(posedge clk) disable iff (!nrst)
    !(abort_done && evt_en_r[BIT_ABORT]) |=> !abort_irq)
    else $error("Abort request not gated");

  a_ovrn_on: assert property (@(posedge clk) disable iff (!nrst)
    (conv_overrun && evt_en_r[BIT_OVRN]) |=> overrun_irq)
    else $error("Overrun request missing");

  a_ovrn_off: assert property (@(posedge clk) disable iff (!nrst)
    !(conv_overrun && evt_en_r[BIT_OVRN]) |=> !overrun_irq)
    else $error("Overrun request not gated");

  // ****************************************
  // Checks on run state
  // ****************************************
  sequence s_run_severe;
    (state_r == ST_RUN) && severe && conv_en;
  endsequence

  sequence s_soft_recover;
    ((state_r == ST_HALTED) && soft_rst_r)
      ##1 ((state_r == ST_IDLE) && conv_en);
  endsequence

  sequence s_mild_run;
    (state_r == ST_RUN) && conv_en && !severe && |(flags & MILD_MASK);
  endsequence

  a_run_halt: assert property (@(posedge clk) disable iff (!nrst)
    s_run_severe |=> (state_r == ST_HALTED) && !conv_run)
    else $error("Severe flag did not halt");

  a_halt_stays: assert property (@(posedge clk) disable iff (!nrst)
    ((state_r == ST_HALTED) && conv_en && !soft_rst_r)
      |=> state_r == ST_HALTED)
    else $error("Left halt without soft-reset");

  a_soft_leaves: assert property (@(posedge clk) disable iff (!nrst)
    ((state_r == ST_HALTED) && soft_rst_r) |=> state_r == ST_IDLE)
    else $error("Soft-reset did not leave halt");

  a_soft_resume: assert property (@(posedge clk) disable iff (!nrst)
    s_soft_recover |=> state_r == ST_RUN)
    else $error("Converter did not resume");

  a_mild_keeps: assert property (@(posedge clk) disable iff (!nrst)
    s_mild_run |=> conv_run)
    else $error("Mild flag stopped conversion");

  a_off_idle: assert property (@(posedge clk) disable iff (!nrst)
    !conv_en |=> (state_r == ST_IDLE) && !conv_run)
    else $error("Converter running while disabled");

  // ****************************************
  // Checks on read data
  // ****************************************
  a_rd_flags: assert property (@(posedge clk) disable iff (!nrst)
    (rd && (addr == OFS_ERR_FLAG)) |=> rdata == $past(flags))
    else $error("Flag read data mismatch");

  a_rd_idle: assert property (@(posedge clk) disable iff (!nrst)
    !rd |=> rdata == 8'h00)
    else $error("Read data not zero without read");

endmodule : adc_error_interrupt_logic
`default_nettype wire

// ==== adc_error_interrupt_logic_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_error_interrupt_logic_bench
  import err_irq_pkg::*;
;
  logic       clk = 1'b0;
  logic       nrst;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  err_event_t err_evt;
  logic       abort_done;
  logic       conv_overrun;
  logic       conv_run;
  logic       err_irq;
  logic       abort_irq;
  logic       overrun_irq;
  logic [7:0] ctrl_v;
  int         num_errors = 0;
  int         comparisons = 0;

  always #4 clk = ~clk;

  adc_error_interrupt_logic u_adc_error_interrupt_logic (
    .clk         (clk),
    .nrst        (nrst),
    .addr        (addr),
    .wdata       (wdata),
    .wr          (wr),
    .rd          (rd),
    .rdata       (rdata),
    .err_evt     (err_evt),
    .abort_done  (abort_done),
    .conv_overrun(conv_overrun),
    .conv_run    (conv_run),
    .err_irq     (err_irq),
    .abort_irq   (abort_irq),
    .overrun_irq (overrun_irq)
  );

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask : rd_chk

  task automatic pulse(input logic [5:0] e);
    @(posedge clk);
    err_evt <= err_event_t'(e);
    @(posedge clk);
    err_evt <= err_event_t'(6'h00);
    repeat (2) @(posedge clk);
  endtask : pulse

  task automatic soft_rst();
    wr_reg(OFS_CTRL, ctrl_v | 8'h02);
    repeat (4) @(posedge clk);
  endtask : soft_rst

  task automatic flag_case(input logic [5:0] e, input logic [7:0] f,
                           input logic sev);
    wr_reg(OFS_ERR_EN, ERR_EN_MASK & ~f);
    pulse(e);
    rd_chk(OFS_ERR_FLAG, f);
    @(negedge clk);
    chk({7'h00, err_irq}, 8'h00);
    chk({7'h00, conv_run}, {7'h00, ~sev});
    rd_chk(OFS_STATUS, sev ? 8'h02 : 8'h01);
    wr_reg(OFS_ERR_EN, f);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({7'h00, err_irq}, 8'h01);
    wr_reg(OFS_ERR_FLAG, 8'h00);
    rd_chk(OFS_ERR_FLAG, f);
    wr_reg(OFS_ERR_FLAG, 8'hff);
    rd_chk(OFS_ERR_FLAG, sev ? f : 8'h00);
    if (sev) begin
      soft_rst();
      rd_chk(OFS_ERR_FLAG, 8'h00);
      @(negedge clk);
      chk({7'h00, conv_run}, 8'h01);
      rd_chk(OFS_STATUS, 8'h01);
      rd_chk(OFS_CTRL, ctrl_v);
    end
  endtask : flag_case

  task automatic ev_chk(input logic [7:0] en);
    wr_reg(OFS_EVT_EN, en);
    @(posedge clk);
    abort_done   <= 1'b1;
    conv_overrun <= 1'b1;
    @(posedge clk);
    abort_done   <= 1'b0;
    conv_overrun <= 1'b0;
    @(negedge clk);
    chk({7'h00, abort_irq}, {7'h00, en[7]});
    chk({7'h00, overrun_irq}, {7'h00, en[6]});
  endtask : ev_chk

  task automatic tally_and_finish();
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // Watchdog and main sequence
  // ****************************************
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    nrst         = 1'b0;
    addr         = 4'h0;
    wdata        = 8'h00;
    wr           = 1'b0;
    rd           = 1'b0;
    err_evt      = err_event_t'(6'h00);
    abort_done   = 1'b0;
    conv_overrun = 1'b0;
    ctrl_v       = 8'h05;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(OFS_ERR_EN, 8'h00);
    rd_chk(OFS_EVT_EN, 8'h00);
    rd_chk(OFS_ERR_FLAG, 8'h00);
    wr_reg(4'h3, 8'hff);
    rd_chk(4'h3, 8'h00);
    wr_reg(OFS_ERR_EN, 8'hff);
    rd_chk(OFS_ERR_EN, 8'hee);
    wr_reg(OFS_EVT_EN, 8'hff);
    rd_chk(OFS_EVT_EN, 8'hc0);
    wr_reg(OFS_CTRL, ctrl_v);
    rd_chk(OFS_CTRL, ctrl_v);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({7'h00, conv_run}, 8'h01);
    flag_case(6'h20, 8'h80, 1'b1);
    flag_case(6'h10, 8'h40, 1'b1);
    flag_case(6'h08, 8'h20, 1'b1);
    flag_case(6'h04, 8'h08, 1'b1);
    flag_case(6'h02, 8'h04, 1'b0);
    flag_case(6'h01, 8'h02, 1'b0);
    ctrl_v = 8'h01;
    wr_reg(OFS_CTRL, ctrl_v);
    pulse(6'h01);
    rd_chk(OFS_ERR_FLAG, 8'h00);
    pulse(6'h02);
    soft_rst();
    rd_chk(OFS_ERR_FLAG, 8'h00);
    pulse(6'h02);
    wr_reg(OFS_CTRL, 8'h00);
    rd_chk(OFS_ERR_FLAG, 8'h00);
    pulse(6'h20);
    rd_chk(OFS_ERR_FLAG, 8'h00);
    ev_chk(8'hc0);
    ev_chk(8'h80);
    ev_chk(8'h40);
    ev_chk(8'h00);
    tally_and_finish();
  end
endmodule : adc_error_interrupt_logic_bench
`default_nettype wire
